// [shared/rsfi_pkg.sv]
// Purpose: constants and types for the return-stack flow instruction unit
// Assumes: 16-bit instruction words, byte-addressed program counter
// Notes:   register offsets are APB byte addresses
package rsfi_pkg;
	localparam int          PC_W        = 21;
	localparam int          STK_DEPTH   = 31;
	localparam logic [20:0] RESET_VEC   = 21'h00_0000;
	localparam logic [20:0] PC_STEP     = 21'h00_0002;
	// instruction cycle phases (four clocks per cycle)
	localparam logic [1:0]  Q_DECODE    = 2'h0;
	localparam logic [1:0]  Q_PUSH      = 2'h1;
	localparam logic [1:0]  Q_POP       = 2'h2;
	localparam logic [1:0]  Q_WB        = 2'h3;
	// opcodes
	localparam logic [15:0] IDLE_OP     = 16'h0000;
	localparam logic [15:0] OP_POP      = 16'h0006;
	localparam logic [15:0] OP_PUSH     = 16'h0005;
	localparam logic [15:0] OP_SWRESET  = 16'h00ff;
	localparam logic [4:0]  OP_RELATIVE_SUBROUTINE_CALL_HI = 5'h1b;
	localparam logic [14:0] OP_INTERRUPT_RETURN_OP   = 15'h0008;
	localparam logic [7:0]  OP_LITERAL_RETURN_OP_HI = 8'h0c;
	// register map
	localparam logic [7:0]  REG_CTRL    = 8'h00;
	localparam logic [7:0]  REG_PC      = 8'h04;
	localparam logic [7:0]  REG_CTX     = 8'h08;
	localparam logic [7:0]  REG_SHADOW  = 8'h0c;
	localparam logic [7:0]  REG_STACK   = 8'h10;
	localparam logic [7:0]  REG_INTEN   = 8'h14;
	localparam int          STK_SP_LSB  = 24;
	localparam logic [16:0] CTX_RST     = 17'h0_0000;

	typedef struct packed {
		logic [4:0] flags;
		logic [3:0] bank;
		logic [7:0] w;
	} rsfi_ctx_t;

	typedef enum logic [2:0] {
		CS_STOP  = 3'b001,
		CS_RUN   = 3'b010,
		CS_FLUSH = 3'b100
	} rsfi_state_t;
endpackage

// [hdl/rsfi_core.sv]
// Purpose: execution of stack and control-flow instructions, APB control
// Assumes: program memory answers prog_addr with prog_data by the Q4 edge
// Notes:   Q phase counter advances every clock while running
//
// Overview of operation
// - stack pop discards top entry, one cycle
// - stack push stores PC plus two
// - relative call opcode 11011 with signed offset
// - relative call pushes return, jumps PC+2+2n
// - relative call takes two cycles, second idle
// - software reset restores pin reset values, except run bit and shadow
// - interrupt return pops PC, sets interrupt enable
// - restore bit copies shadows into live registers
// - literal return loads W and pops PC
// - literal return two cycles, writes in Q4
`timescale 1ns/1ps
module rsfi_core
	import rsfi_pkg::*;
#(
	parameter int DEPTH = STK_DEPTH
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [15:0]       prog_data,
	output logic      [PC_W-1:0]   prog_addr,
	output logic                   high_prio_global_int_en,
	output logic                   low_prio_global_int_en
);
	localparam int SP_W = $clog2(DEPTH + 1);
	localparam logic [SP_W-1:0] SP_ONE  = SP_W'(1);
	localparam logic [SP_W-1:0] SP_FULL = SP_W'(DEPTH);

	logic [PC_W-1:0] stk_mem [DEPTH];
	logic [PC_W-1:0] pc_r, pc_nxt;
	logic [SP_W-1:0] sp_r, sp_nxt;
	logic [15:0]     ir_r, ir_nxt;
	logic [1:0]      q_r, q_nxt;
	rsfi_state_t     st_r, st_nxt;
	rsfi_ctx_t       ctx_r, ctx_nxt;
	rsfi_ctx_t       shadow_r;
	logic            run_r;

	// decode
	wire logic exec       = (st_r == CS_RUN);
	wire logic op_pop     = (ir_r == OP_POP);
	wire logic op_push    = (ir_r == OP_PUSH);
	wire logic op_relative_subroutine_call   = (ir_r[15:11] == OP_RELATIVE_SUBROUTINE_CALL_HI);
	wire logic op_swreset = (ir_r == OP_SWRESET);
	wire logic op_interrupt_return_op  = (ir_r[15:1] == OP_INTERRUPT_RETURN_OP);
	wire logic op_literal_return_op   = (ir_r[15:8] == OP_LITERAL_RETURN_OP_HI);
	wire logic restore    = ir_r[0];
	wire logic at_wb      = (q_r == Q_WB);
	wire logic two_cycle  = op_relative_subroutine_call | op_interrupt_return_op | op_literal_return_op;
	wire logic stk_empty  = (sp_r == '0);
	wire logic stk_full   = (sp_r == SP_FULL);
	// signed word offset doubled to bytes, -1024..1023 words
	wire logic [PC_W-1:0] rel_off =
		{{(PC_W - 12){ir_r[10]}}, ir_r[10:0], 1'b0};
	wire logic [PC_W-1:0] stack_top_entry =
		stk_empty ? '0 : stk_mem[sp_r - SP_ONE];
	// pc_r already holds the next fetch address, i.e. PC+2
	wire logic do_push = exec && q_r == Q_PUSH && !stk_full &&
		(op_push | op_relative_subroutine_call);
	wire logic do_pop  = exec && !stk_empty &&
		((op_pop && q_r == Q_POP) ||
		 ((op_interrupt_return_op | op_literal_return_op) && at_wb));
	wire logic do_swrst = exec && op_swreset && at_wb;
	wire logic set_gie  = exec && op_interrupt_return_op && at_wb;

	// APB decode
	wire logic apb_setup = psel && !penable;
	wire logic apb_done  = psel && penable && pready;
	wire logic apb_wr    = apb_done && pwrite;
	wire logic wr_ctrl   = apb_wr && paddr == REG_CTRL;
	wire logic wr_shadow = apb_wr && paddr == REG_SHADOW;
	wire logic wr_inten  = apb_wr && paddr == REG_INTEN;
	wire logic addr_ok   = paddr == REG_CTRL || paddr == REG_PC ||
		paddr == REG_CTX || paddr == REG_SHADOW ||
		paddr == REG_STACK || paddr == REG_INTEN;
	wire logic [31:0] stack_word =
		(32'(sp_r) << STK_SP_LSB) | 32'(stack_top_entry);
	wire logic [31:0] rd_mux =
		paddr == REG_CTRL   ? {31'h0, run_r} :
		paddr == REG_PC     ? 32'(pc_r) :
		paddr == REG_CTX    ? 32'(ctx_r) :
		paddr == REG_SHADOW ? 32'(shadow_r) :
		paddr == REG_STACK  ? stack_word :
		paddr == REG_INTEN  ? {30'h0, low_prio_global_int_en,
		                       high_prio_global_int_en} : 32'h0000_0000;
	// return from interrupt re-enables the level that was masked
	wire logic set_h = set_gie && !high_prio_global_int_en;
	wire logic set_l = set_gie && high_prio_global_int_en;

	always_comb begin
		pc_nxt  = pc_r;
		sp_nxt  = sp_r;
		ir_nxt  = ir_r;
		ctx_nxt = ctx_r;
		st_nxt  = st_r;
		q_nxt   = q_r;
		if (do_push)
			sp_nxt = sp_r + SP_ONE;
		if (do_pop)
			sp_nxt = sp_r - SP_ONE;
		unique case (st_r)
			CS_STOP: begin
				q_nxt = Q_DECODE;
				if (run_r)
					st_nxt = CS_RUN;
			end
			CS_RUN: begin
				q_nxt = q_r + 2'h1;
				if (at_wb) begin
					pc_nxt = pc_r + PC_STEP;
					ir_nxt = prog_data;
					if (op_relative_subroutine_call)
						pc_nxt = pc_r + rel_off;
					if (op_interrupt_return_op | op_literal_return_op)
						pc_nxt = stack_top_entry;
					if (op_interrupt_return_op && restore)
						ctx_nxt = shadow_r;
					if (op_literal_return_op)
						ctx_nxt.w = ir_r[7:0];
					if (two_cycle) begin
						ir_nxt = IDLE_OP;
						st_nxt = CS_FLUSH;
					end else if (!run_r) begin
						st_nxt = CS_STOP;
					end
					if (op_swreset) begin
						pc_nxt  = RESET_VEC;
						sp_nxt  = '0;
						ir_nxt  = IDLE_OP;
						ctx_nxt = CTX_RST;
					end
				end
			end
			CS_FLUSH: begin
				// second cycle does nothing but refetch
				q_nxt = q_r + 2'h1;
				if (at_wb) begin
					pc_nxt = pc_r + PC_STEP;
					ir_nxt = prog_data;
					st_nxt = run_r ? CS_RUN : CS_STOP;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_r  <= RESET_VEC;
			sp_r  <= '0;
			ir_r  <= IDLE_OP;
			ctx_r <= CTX_RST;
			st_r  <= CS_STOP;
			q_r   <= Q_DECODE;
		end else begin
			pc_r  <= pc_nxt;
			sp_r  <= sp_nxt;
			ir_r  <= ir_nxt;
			ctx_r <= ctx_nxt;
			st_r  <= st_nxt;
			q_r   <= q_nxt;
		end
	end

	always_ff @(posedge pclk) begin
		if (do_push)
			stk_mem[sp_r] <= pc_r;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prog_addr <= RESET_VEC;
		else
			prog_addr <= pc_nxt;
	end

	// hardware set wins over a software clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_prio_global_int_en <= 1'b0;
			low_prio_global_int_en  <= 1'b0;
		end else if (do_swrst) begin
			high_prio_global_int_en <= 1'b0;
			low_prio_global_int_en  <= 1'b0;
		end else begin
			high_prio_global_int_en <= set_h | (wr_inten ? pwdata[0]
				: high_prio_global_int_en);
			low_prio_global_int_en  <= set_l | (wr_inten ? pwdata[1]
				: low_prio_global_int_en);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_r    <= 1'b0;
			shadow_r <= CTX_RST;
		end else begin
			if (wr_ctrl)
				run_r <= pwdata[0];
			if (wr_shadow)
				shadow_r <= rsfi_ctx_t'(pwdata[16:0]);
		end
	end

	// no wait state: ready in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= apb_setup;
			pslverr <= apb_setup && !addr_ok;
			prdata  <= (apb_setup && !pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_pop_discard: assert property (
		exec && op_pop && q_r == Q_POP && !stk_empty |=>
		sp_r == $past(sp_r) - SP_ONE && ctx_r == $past(ctx_r))
		else $error("pop did not drop one entry cleanly");
	a_push_value: assert property (
		exec && op_push && q_r == Q_PUSH && !stk_full |=>
		stack_top_entry == $past(pc_r) && sp_r == $past(sp_r) + SP_ONE)
		else $error("push stored wrong return address");
	a_relative_subroutine_call_target: assert property (
		exec && op_relative_subroutine_call && at_wb |=>
		pc_r == $past(pc_r) + $past(rel_off) &&
		(!$past(do_push, 3) || stack_top_entry == $past(pc_r)))
		else $error("relative call target or return wrong");
	a_relative_subroutine_call_idle: assert property (
		exec && two_cycle && at_wb |=>
		(st_r == CS_FLUSH && ir_r == IDLE_OP) [*4] ##1 st_r != CS_FLUSH)
		else $error("two-cycle op second cycle not idle");
	a_swreset_state: assert property (
		do_swrst |=> pc_r == RESET_VEC && sp_r == '0 &&
		ctx_r == CTX_RST && !high_prio_global_int_en)
		else $error("software reset left state behind");
	a_interrupt_return_op_gie: assert property (
		set_gie && !stk_empty |=> pc_r == $past(stack_top_entry) &&
		(high_prio_global_int_en || low_prio_global_int_en) &&
		sp_r == $past(sp_r) - SP_ONE)
		else $error("interrupt return pop or enable wrong");
	a_interrupt_return_op_shadow: assert property (
		set_gie |=> ctx_r == ($past(restore) ? $past(shadow_r)
		: $past(ctx_r)))
		else $error("shadow restore mismatch");
	a_literal_return_op_load: assert property (
		exec && op_literal_return_op && at_wb && !stk_empty |=>
		ctx_r.w == $past(ir_r[7:0]) && pc_r == $past(stack_top_entry))
		else $error("literal return load wrong");
	a_literal_return_op_q4only: assert property (
		exec && op_literal_return_op && !at_wb |=> ctx_r == $past(ctx_r))
		else $error("literal return wrote W before Q4");
	a_apb_answer: assert property (
		apb_setup |=> pready && pslverr == !$past(addr_ok))
		else $error("apb answer not one cycle after setup");
	a_apb_quiet: assert property (
		!apb_setup |=> !pready && !pslverr)
		else $error("apb answer without a setup cycle");
	a_apb_wr_zero: assert property (
		apb_setup && pwrite |=> prdata == 32'h0000_0000)
		else $error("read data driven during a write");

	a_pop_empty: assert property (
		exec && op_pop && q_r == Q_POP && stk_empty |=> sp_r == '0)
		else $error("pop of empty stack moved the pointer");
	a_push_full: assert property (
		exec && op_push && q_r == Q_PUSH && stk_full |=>
		sp_r == SP_FULL)
		else $error("push onto full stack moved the pointer");
	a_stack_flags: assert property (
		exec && (op_push || op_pop) |=> ctx_r == $past(ctx_r))
		else $error("stack push or pop changed the flags");
	a_sp_bound: assert property (sp_r <= SP_FULL)
		else $error("stack pointer beyond depth");
	a_relative_subroutine_call_push: assert property (
		exec && op_relative_subroutine_call && q_r == Q_PUSH && !stk_full |=>
		sp_r == $past(sp_r) + SP_ONE && stack_top_entry == $past(pc_r))
		else $error("relative call did not push return address");

	a_interrupt_return_op_empty: assert property (
		set_gie && stk_empty |=> pc_r == '0 && sp_r == '0)
		else $error("interrupt return from empty stack wrong");
	a_interrupt_return_op_level: assert property (
		set_gie |=> high_prio_global_int_en &&
		(!$past(high_prio_global_int_en) || low_prio_global_int_en))
		else $error("interrupt return set the wrong enable");
	a_literal_return_op_pop: assert property (
		exec && op_literal_return_op && at_wb && !stk_empty |=>
		sp_r == $past(sp_r) - SP_ONE)
		else $error("literal return did not pop");
	a_swreset_ir: assert property (
		do_swrst |=> ir_r == IDLE_OP && !low_prio_global_int_en)
		else $error("software reset kept prefetch or low enable");
	a_idle_quiet: assert property (
		exec && ir_r == IDLE_OP |=>
		sp_r == $past(sp_r) && ctx_r == $past(ctx_r))
		else $error("idle instruction changed state");

	a_fetch_hold: assert property (
		!at_wb |=> $stable(prog_addr))
		else $error("fetch address moved inside a cycle");
	a_fetch_is_pc: assert property (prog_addr == pc_r)
		else $error("fetch address differs from pc");
	a_flush_refetch: assert property (
		st_r == CS_FLUSH && at_wb |=>
		pc_r == $past(pc_r) + PC_STEP && ir_r == $past(prog_data))
		else $error("idle cycle did not fetch from new pc");
	a_q_advance: assert property (
		st_r != CS_STOP |=> q_r == $past(q_r) + 2'h1)
		else $error("phase counter skipped");
	a_run_start: assert property (
		st_r == CS_STOP && run_r |=> st_r == CS_RUN && q_r == Q_DECODE)
		else $error("core did not start on run");
	a_stop_frozen: assert property (
		st_r == CS_STOP |=> pc_r == $past(pc_r) && sp_r == $past(sp_r))
		else $error("stopped core changed pc or stack");

	a_ctrl_write: assert property (
		wr_ctrl |=> run_r == $past(pwdata[0]))
		else $error("run bit write lost");
	a_shadow_write: assert property (
		wr_shadow |=> shadow_r == $past(pwdata[16:0]))
		else $error("shadow write lost");
	a_inten_write: assert property (
		wr_inten && !set_gie && !do_swrst |=>
		high_prio_global_int_en == $past(pwdata[0]) &&
		low_prio_global_int_en == $past(pwdata[1]))
		else $error("interrupt enable write lost");

	c_relative_subroutine_call: cover property (exec && op_relative_subroutine_call && at_wb);
	c_interrupt_return_op_s: cover property (set_gie && restore);
	c_literal_return_op: cover property (exec && op_literal_return_op && at_wb);
	c_swreset: cover property (do_swrst);
	c_interrupt_return_op_plain: cover property (set_gie && !restore);
endmodule // rsfi_core

// [test/rsfi_prog_mem.sv]
// Purpose: program memory model feeding instruction words
// Assumes: bench loads words through the mem array
// Notes:   one clock read latency, stale word until then
`timescale 1ns/1ps
module rsfi_prog_mem
	import rsfi_pkg::*;
(
	input  wire logic [PC_W-1:0] prog_addr,
	input  wire logic            pclk,
	output logic      [15:0]     prog_data
);
	logic [15:0] mem [0:63];

	initial begin
		foreach (mem[i]) mem[i] = IDLE_OP;
		prog_data = IDLE_OP;
	end

	always @(posedge pclk) begin
		prog_data <= mem[prog_addr[6:1]];
	end
endmodule // rsfi_prog_mem

// [test/rsfi_core_bench.sv]
// Purpose: self-checking bench for rsfi_core
// Assumes: program ends in a call-to-self spin that fills the stack
// Notes:   results are judged once the stack register settles
`timescale 1ns/1ps
module rsfi_core_bench;
	import rsfi_pkg::*;
	logic            pclk, presetn, psel, penable, pwrite;
	logic [7:0]      paddr;
	logic [31:0]     pwdata, prdata;
	logic            pready, pslverr, hi_en, lo_en;
	logic [15:0]     prog_data;
	logic [PC_W-1:0] prog_addr;
	int              err_count, samples_checked;
	logic [31:0]     full_sp;

	rsfi_core rsfi_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.prog_data(prog_data), .prog_addr(prog_addr),
		.high_prio_global_int_en(hi_en), .low_prio_global_int_en(lo_en));
	rsfi_prog_mem rsfi_prog_mem_inst (.prog_addr(prog_addr), .pclk(pclk),
		.prog_data(prog_data));

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	task results;
		if (err_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		check(r, exp);
	endtask

	// poll the stack register until it shows the expected word
	task automatic settle(input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		for (int i = 0; i < 300; i++) begin
			apb(1'b0, REG_STACK, 32'h0000_0000, r, e);
			if (r === exp)
				break;
		end
		check(r, exp);
	endtask

	task automatic t_reset;
		rd_chk(REG_CTRL, 32'h0000_0000);
		rd_chk(REG_STACK, 32'h0000_0000);
		rd_chk(REG_CTX, 32'h0000_0000);
		rd_chk(REG_INTEN, 32'h0000_0000);
		rd_chk(REG_PC, 32'h0000_0000);
		rd_chk(REG_SHADOW, 32'h0000_0000);
	endtask

	task automatic t_unmapped;
		logic [31:0] r;
		logic        e;
		apb(1'b0, 8'h18, 32'h0000_0000, r, e);
		check({31'h0, e}, 32'h0000_0001);
		check(r, 32'h0000_0000);
		apb(1'b1, 8'h18, 32'hffff_ffff, r, e);
		check({31'h0, e}, 32'h0000_0001);
		apb(1'b1, REG_CTX, 32'hffff_ffff, r, e);
		check({31'h0, e}, 32'h0000_0000);
		rd_chk(REG_CTX, 32'h0000_0000);
		rd_chk(REG_PC, 32'h0000_0000);
	endtask

	task automatic t_flow;
		rsfi_prog_mem_inst.mem[0] = {OP_RELATIVE_SUBROUTINE_CALL_HI, 11'h00f};
		rsfi_prog_mem_inst.mem[1] = {OP_RELATIVE_SUBROUTINE_CALL_HI, 11'h7ff};
		rsfi_prog_mem_inst.mem[16] = OP_PUSH;
		rsfi_prog_mem_inst.mem[17] = OP_PUSH;
		rsfi_prog_mem_inst.mem[18] = OP_POP;
		rsfi_prog_mem_inst.mem[19] = {OP_RELATIVE_SUBROUTINE_CALL_HI, 11'h00c};
		rsfi_prog_mem_inst.mem[32] = {OP_INTERRUPT_RETURN_OP, 1'b1};
		rsfi_prog_mem_inst.mem[20] = OP_POP;
		rsfi_prog_mem_inst.mem[21] = {OP_LITERAL_RETURN_OP_HI, 8'h5a};
		wr(REG_SHADOW, 32'h0001_a3c7);
		wr(REG_CTRL, 32'h0000_0001);
		settle(full_sp | 32'h0000_0004);
		rd_chk(REG_CTX, 32'h0001_a35a);
		rd_chk(REG_INTEN, 32'h0000_0001);
		check({30'h0, hi_en, lo_en}, 32'h0000_0002);
	endtask

	task automatic t_swreset;
		@(posedge pclk);
		rsfi_prog_mem_inst.mem[0] <= {OP_RELATIVE_SUBROUTINE_CALL_HI, 11'h7ff};
		rsfi_prog_mem_inst.mem[1] <= OP_SWRESET;
		settle(full_sp | 32'h0000_0002);
		rd_chk(REG_CTX, 32'h0000_0000);
		rd_chk(REG_INTEN, 32'h0000_0000);
		rd_chk(REG_SHADOW, 32'h0001_a3c7);
		check({30'h0, hi_en, lo_en}, 32'h0000_0000);
	endtask

	// plain interrupt return while the high enable is already set
	task automatic t_intret;
		wr(REG_INTEN, 32'h0000_0001);
		@(posedge pclk);
		rsfi_prog_mem_inst.mem[1] <= {OP_RELATIVE_SUBROUTINE_CALL_HI, 11'h7ff};
		rsfi_prog_mem_inst.mem[0] <= {OP_INTERRUPT_RETURN_OP, 1'b0};
		settle(full_sp | 32'h0000_0004);
		rd_chk(REG_CTX, 32'h0000_0000);
		rd_chk(REG_INTEN, 32'h0000_0003);
		check({30'h0, hi_en, lo_en}, 32'h0000_0003);
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		results();
	end

	initial begin
		err_count = 0;
		samples_checked = 0;
		full_sp = 32'(STK_DEPTH) << STK_SP_LSB;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_unmapped();
		t_flow();
		t_swreset();
		t_intret();
		results();
	end
endmodule // rsfi_core_bench
